// >>> design/wlv_pkg.sv
// Function
// - mr1 bit seven enters write leveling mode
// - dqs rising edge samples ck, prime dq reports
// - narrow parts: feedback on dq0, others low
// - wide parts: dq0 lower, dq8 upper lane
// - output buffer bit one disables strobe, dq
// - odt switches only dqs termination
// - allowed termination values depend on buffer bit
// - buffers off, odt low: all off, high-z
// - controller issues only nop or deselect
// - controller levels one rank at a time
// - odt raised after tmod, before dqs low; here odt and dqs_oe both rise on entering ST_PRE
// - dqs low after delay, toggle after wlmrd
// - toggles meet minimum high and low widths
// - prime dq follows capture within output delay
// - controller does not drive dq
// - controller steps delay until zero-to-one seen
// - controller keeps dqs after last edge, stops; here dqs_oe drops at the last falling edge, on entering ST_TAIL
// - controller drops odt after dqs stops; here odt and dqs_oe drop in the same cycle
// - leveling disabled by mrs after termination off
package wlv_pkg;
  localparam int DQ_W = 16;
  localparam int MR_W = 16;
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR1_RTT0_BIT = 2;
  localparam int MR1_RTT1_BIT = 6;
  localparam int MR1_RTT2_BIT = 9;
  localparam int UPPER_PRIME = 8;
  localparam logic [2:0] RTT_OFF = 3'h0;
  localparam logic [2:0] RTT_60 = 3'h1;
  localparam logic [2:0] RTT_120 = 3'h2;
  localparam logic [2:0] RTT_40 = 3'h3;
  localparam int CLK_NS = 40;
  localparam int TMOD_NS = 360;
  localparam int TMOD_CYC = (TMOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWLMRD_NS = 1000;
  localparam int TWLMRD_CYC = (TWLMRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_DIV = 4;
  localparam int TOGGLES = 4;
  localparam int TAP_MAX = 32;
  localparam int TAIL_CYC = 16;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
endpackage : wlv_pkg

// >>> design/wlv_link_if.sv
`timescale 1ns/1ps
interface wlv_link_if;
  logic ck;
  logic wl_enable;
  logic out_disable;
  logic [2:0] rtt_nom;
  logic odt;
  logic dqs_upper;
  logic dqs_lower;
  logic dqs_oe;
  logic [wlv_pkg::DQ_W-1:0] dq_out;
  logic [wlv_pkg::DQ_W-1:0] dq_oe;
  logic dqs_term;
  modport device (input ck, input wl_enable, input out_disable, input rtt_nom, input odt,
    input dqs_upper, input dqs_lower, input dqs_oe, output dq_out, output dq_oe,
    output dqs_term);
  modport ctrl (output ck, output wl_enable, output out_disable, output rtt_nom,
    output odt, output dqs_upper, output dqs_lower, output dqs_oe, input dq_out,
    input dq_oe, input dqs_term);
endinterface : wlv_link_if

// >>> design/wlv_device.sv
`timescale 1ns/1ps
module wlv_device (
  input wire logic clk,
  input wire logic reset_n,
  wlv_link_if.device link,
  input wire logic wide_part,
  output logic leveling,
  output logic rtt_illegal
);
  typedef struct packed {
    logic [2:0] ck_s;
    logic [2:0] lo_s;
    logic [2:0] up_s;
    logic [1:0] wl_s;
    logic [1:0] qoff_s;
    logic [1:0] odt_s;
    logic fb_lo;
    logic fb_up;
    logic seen;
  } wlv_dev_type;
  wlv_dev_type r;
  wlv_dev_type next_r;
  logic active;
  logic drive;
  always_comb
  begin
    next_r = r;
    // sync chains; stage 0 only feeds stage 1
    next_r.ck_s = {r.ck_s[1:0], link.ck};
    next_r.lo_s = {r.lo_s[1:0], link.dqs_lower};
    next_r.up_s = {r.up_s[1:0], link.dqs_upper};
    next_r.wl_s = {r.wl_s[0], link.wl_enable};
    next_r.qoff_s = {r.qoff_s[0], link.out_disable};
    next_r.odt_s = {r.odt_s[0], link.odt};
    active = r.wl_s[1];
    drive = active && !r.qoff_s[1];
    if (!active)
    begin
      next_r.seen = 1'b0;
      next_r.fb_lo = 1'b0;
      next_r.fb_up = 1'b0;
    end
    else if (drive)
    begin
      // held until the next captured edge
      if (r.lo_s[1] && !r.lo_s[2])
      begin
        next_r.fb_lo = r.ck_s[2];
        next_r.seen = 1'b1;
      end
      if (r.up_s[1] && !r.up_s[2])
        next_r.fb_up = r.ck_s[2];
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end
  always_comb
  begin
    link.dq_out = '0;
    link.dq_out[0] = r.fb_lo;
    if (wide_part)
      link.dq_out[wlv_pkg::UPPER_PRIME] = r.fb_up;
    // other lines low once driving; x8 upper byte not bonded
    link.dq_oe = '0;
    if (drive)
      link.dq_oe = wide_part ? '1 : {{(wlv_pkg::DQ_W/2){1'b0}}, {(wlv_pkg::DQ_W/2){1'b1}}};
  end
  assign link.dqs_term = active && r.odt_s[1] && (link.rtt_nom != wlv_pkg::RTT_OFF);
  assign leveling = active;
  // buffers on allow only 40/60/120
  assign rtt_illegal = drive && r.odt_s[1] && !(link.rtt_nom == wlv_pkg::RTT_40
    || link.rtt_nom == wlv_pkg::RTT_60 || link.rtt_nom == wlv_pkg::RTT_120);
endmodule : wlv_device

// >>> design/wlv_ctrl.sv
`timescale 1ns/1ps
module wlv_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  wlv_link_if.ctrl link,
  input wire logic start,
  input wire logic level_rank,
  output logic busy,
  output logic done,
  output logic [7:0] tap
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_MOD = 3'b001, ST_PRE = 3'b010, ST_TOG = 3'b011,
    ST_TAIL = 3'b100, ST_EXIT = 3'b101
  } wlv_st_type;
  typedef struct packed {
    wlv_st_type st;
    logic [7:0] cnt;
    logic [7:0] div;
    logic [7:0] tog;
    logic [7:0] tap;
    logic ck;
    logic dqs;
    logic [1:0] fb_s;
    logic last;
    logic done;
  } wlv_ctl_type;
  wlv_ctl_type r;
  wlv_ctl_type next_r;
  always_comb
  begin
    next_r = r;
    next_r.fb_s = {r.fb_s[0], link.dq_out[0]};
    next_r.div = r.div + 8'(1);
    if (r.div == 8'(wlv_pkg::HALF_DIV - 1))
    begin
      next_r.div = wlv_pkg::CNT_ZERO;
      next_r.ck = !r.ck;
    end
    next_r.cnt = r.cnt + 8'(1);
    unique case (r.st)
      ST_IDLE:
      begin
        next_r.cnt = wlv_pkg::CNT_ZERO;
        if (start)
        begin
          next_r.st = ST_MOD;
          next_r.done = 1'b0;
          next_r.tap = wlv_pkg::CNT_ZERO;
        end
      end
      ST_MOD:
        if (r.cnt == 8'(wlv_pkg::TMOD_CYC))
        begin
          next_r.st = ST_PRE;
          next_r.cnt = wlv_pkg::CNT_ZERO;
        end
      ST_PRE:
        if (r.cnt == 8'(wlv_pkg::TWLMRD_CYC))
        begin
          next_r.st = ST_TOG;
          next_r.cnt = wlv_pkg::CNT_ZERO;
          next_r.tog = wlv_pkg::CNT_ZERO;
        end
      ST_TOG:
        // dqs high/low each eight clk, above minimum widths
        if (r.cnt == 8'(2 * wlv_pkg::HALF_DIV - 1))
        begin
          next_r.cnt = wlv_pkg::CNT_ZERO;
          next_r.dqs = !r.dqs;
          if (r.dqs)
          begin
            next_r.tog = r.tog + 8'(1);
            if (r.tog == 8'(wlv_pkg::TOGGLES - 1))
            begin
              next_r.tog = wlv_pkg::CNT_ZERO;
              // step delay until feedback goes 0 to 1
              if (!r.last && r.fb_s[1] && r.tap != wlv_pkg::CNT_ZERO)
                next_r.st = ST_TAIL;
              else if (r.tap == 8'(wlv_pkg::TAP_MAX - 1))
                next_r.st = ST_TAIL;
              else
                next_r.tap = r.tap + 8'(1);
              next_r.last = r.fb_s[1];
            end
          end
        end
      ST_TAIL:
        if (r.cnt == 8'(wlv_pkg::TAIL_CYC))
        begin
          next_r.st = ST_EXIT;
          next_r.cnt = wlv_pkg::CNT_ZERO;
        end
      ST_EXIT:
        if (r.cnt == 8'(wlv_pkg::TMOD_CYC))
        begin
          next_r.st = ST_IDLE;
          next_r.done = 1'b1;
        end
      default:
        next_r.st = ST_IDLE;
    endcase
    if (r.st != ST_TOG)
      next_r.dqs = 1'b0;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end
  // coarse delay model: odd taps invert the ck phase seen at the strobe
  assign link.ck = r.ck ^ r.tap[0];
  assign link.wl_enable = r.st inside {ST_MOD, ST_PRE, ST_TOG, ST_TAIL};
  assign link.out_disable = !level_rank;
  assign link.rtt_nom = wlv_pkg::RTT_40;
  assign link.odt = r.st inside {ST_PRE, ST_TOG};
  assign link.dqs_lower = r.dqs;
  assign link.dqs_upper = r.dqs;
  assign link.dqs_oe = r.st inside {ST_PRE, ST_TOG};
  assign busy = r.st != ST_IDLE;
  assign done = r.done;
  assign tap = r.tap;
endmodule : wlv_ctrl

// >>> test/wlv_link_checker.sv
`timescale 1ns/1ps
module wlv_link_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wl_enable,
  input wire logic out_disable,
  input wire logic odt,
  input wire logic [2:0] rtt_nom,
  input wire logic dqs_lower,
  input wire logic [wlv_pkg::DQ_W-1:0] dq_out,
  input wire logic [wlv_pkg::DQ_W-1:0] dq_oe,
  input wire logic dqs_term
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // device sees wl_enable and odt through two sync flops
  term_odt_a: assert property (dqs_term == ($past(wl_enable, 2) && $past(odt, 2)
      && rtt_nom != wlv_pkg::RTT_OFF))
    else $error("bad term");
  standby_a: assert property (out_disable && !$past(odt, 2) |-> !dqs_term)
    else $error("standby term");
  // four samples cover the two-flop sync with one to spare; dq_oe is not registered
  qoff_hiz_a: assert property (out_disable [*4] |-> dq_oe == '0)
    else $error("dq on, qoff");
  exit_hiz_a: assert property (!wl_enable [*4] |-> dq_oe == '0)
    else $error("dq on, idle");
  prime_on_a: assert property ((wl_enable && !out_disable) [*4] |-> dq_oe[0])
    else $error("dq0 off");
  others_low_a: assert property ((dq_out & 16'hfefe) == 16'h0000)
    else $error("dq not low");
  fb_time_a: assert property ($changed(dq_out[0]) && wl_enable |->
      $past(dqs_lower, 2) != $past(dqs_lower, 5))
    else $error("fb late");
  fb_hold_a: assert property ((wl_enable && $stable(dqs_lower)) [*6] |->
      $stable(dq_out[0]))
    else $error("fb moved");
  fb_rise_c: cover property ($rose(dq_out[0]));
  term_on_c: cover property (wl_enable && dqs_term);
  quiet_c: cover property (wl_enable && out_disable);
endmodule : wlv_link_checker

// >>> test/dram_write_leveling_feedback_tb_top.sv
`timescale 1ns/1ps
module dram_write_leveling_feedback_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wide_part = 1'b0;
  logic start = 1'b0;
  logic level_rank = 1'b1;
  logic leveling, rtt_illegal, busy, done;
  logic [7:0] tap;
  logic [4:0] saw;
  int fail_count = 0;
  int checks_done = 0;
  wlv_link_if link ();
  wlv_device wlv_device_i (.clk(clk), .reset_n(reset_n), .link(link),
    .wide_part(wide_part), .leveling(leveling), .rtt_illegal(rtt_illegal));
  wlv_ctrl wlv_ctrl_i (.clk(clk), .reset_n(reset_n), .link(link), .start(start),
    .level_rank(level_rank), .busy(busy), .done(done), .tap(tap));
  wlv_link_checker wlv_link_checker_i (.clk(clk), .reset_n(reset_n),
    .wl_enable(link.wl_enable), .out_disable(link.out_disable), .odt(link.odt),
    .rtt_nom(link.rtt_nom), .dqs_lower(link.dqs_lower), .dq_out(link.dq_out),
    .dq_oe(link.dq_oe), .dqs_term(link.dqs_term));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // sticky record: {illegal, dq0 high, dq8 on, dq0 on, leveling}
  task automatic run(input logic wide, input logic rank);
    int n;
    @(negedge clk);
    wide_part = wide;
    level_rank = rank;
    start = 1'b1;
    saw = 5'h00;
    @(negedge clk);
    start = 1'b0;
    for (n = 0; n < 5000 && busy !== 1'b0; n++)
    begin
      @(negedge clk);
      saw = saw | {rtt_illegal, link.dq_out[0], link.dq_oe[8], link.dq_oe[0], leveling};
    end
    chk(done === 1'b1 && n < 5000, "no finish");
    chk(leveling === 1'b0 && link.dq_oe === 16'h0000, "mode left on");
  endtask : run
  task automatic level_narrow();
    run(1'b0, 1'b1);
    chk(saw === 5'h0b, "narrow lanes");
    chk(tap < 8'(wlv_pkg::TAP_MAX), "tap range");
  endtask : level_narrow
  task automatic level_wide();
    run(1'b1, 1'b1);
    chk(saw === 5'h0f, "wide lanes");
  endtask : level_wide
  // unlevelled rank never answers, so the search must run out
  task automatic standby_rank();
    run(1'b1, 1'b0);
    chk(saw === 5'h01, "standby drove");
    chk(tap === 8'(wlv_pkg::TAP_MAX - 1), "no run out");
  endtask : standby_rank
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    level_narrow();
    level_wide();
    standby_rank();
    level_narrow();
    end_of_test();
  end
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test();
  end
endmodule : dram_write_leveling_feedback_tb_top
